// >>> dv/hdlc_datalink_control_tb.sv
// Self-checking bench for the data-link control block.
`timescale 1ns/1ns
`default_nettype none
`include "hdlc_dl_params.svh"
module hdlc_datalink_control_tb;
  logic        clk, rst, reg_wr, reg_rd, irq, slc, sfb, wbuf;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, o3;
  logic [1:0]  fmt;
  logic        o2v, o2e, o2r, s3, v3, e3, acc, dis, tick, ebit, lbit;
  logic        hold, mmode, idle, fcs;
  logic [15:0] got;
  int          err_count = 0;
  int          comparisons = 0;

  hdlc_datalink_control dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .framing_format(fmt),
    .slc_link_active(slc), .sf_bits_select(sfb), .rx2_octet_valid(o2v), .rx2_frame_end(o2e),
    .rx2_bos_repeat(o2r), .rx2_write_buffer(wbuf), .rx3_frame_start(s3), .rx3_octet_valid(v3),
    .rx3_octet(o3), .rx3_frame_end(e3), .rx3_frame_accept(acc), .rx3_frame_discard(dis),
    .tx3_bit_tick(tick), .tx3_engine_bit(ebit), .tx3_line_bit(lbit), .tx3_engine_hold(hold),
    .tx3_message_mode(mmode), .tx3_idle_flags(idle), .tx3_fcs_append(fcs));

  remote_terminal peer (.clk(clk), .rx2_octet_valid(o2v), .rx2_frame_end(o2e), .rx2_bos_repeat(o2r),
    .rx3_frame_start(s3), .rx3_octet_valid(v3), .rx3_octet(o3), .rx3_frame_end(e3),
    .rx3_frame_accept(acc), .rx3_frame_discard(dis), .tx3_bit_tick(tick), .tx3_engine_bit(ebit),
    .tx3_line_bit(lbit));

  // Free-running 125 MHz clock.
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Host port cycles; a gap edge follows every strobe.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk) begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
    end
    @(posedge clk) reg_wr <= 1'h0;
  endtask

  // Read data stands only in the cycle after the strobe, so it is sampled there.
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk) begin
      reg_addr <= a;
      reg_rd <= 1'h1;
    end
    @(posedge clk) reg_rd <= 1'h0;
    #1 chk({8'h00, reg_rdata}, {8'h00, e});
  endtask

  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // Hang guard.
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("unexpected at %0t: run did not finish", $time);
    stop_test;
  end

  // Main sequence.
  initial begin
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata, fmt} = {1'h1, 24'h000000};
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    settle;
    rd(`DLC3_ADDR, 8'h00);
    rd(`RXBC2_ADDR, 8'h00);
    rd(12'h152, 8'h00);
    chk({irq, slc, sfb, wbuf, lbit, hold, mmode, idle, fcs}, 16'h0070);
    $display("test reset finished");

    wr(`DLC3_ADDR, 8'h80);
    for (int f = 0; f < 3; f++) begin
      @(posedge clk) fmt <= f[1:0];
      settle;
      chk({slc, sfb}, (f != 0) ? 16'h0002 : 16'h0001);
    end
    wr(`DLC3_ADDR, 8'h00);
    settle;
    chk({slc, sfb}, 16'h0001);
    $display("test loop link finished");

    wr(`RX2_MODE_ADDR, 8'h01);
    peer.msg2(5);
    rd(`RXBC2_ADDR, 8'h85);
    chk(wbuf, 16'h0000);
    rd(`IRQ_STATUS_ADDR, 8'h01);
    chk(irq, 16'h0000);
    wr(`IRQ_MASK_ADDR, 8'h01);
    settle;
    chk(irq, 16'h0001);
    peer.msg2(3);
    rd(`RXBC2_ADDR, 8'h03);
    wr(`IRQ_STATUS_ADDR, 8'h01);
    settle;
    chk(irq, 16'h0000);
    $display("test message receive finished");

    // Bit 7 is hardware owned, so only the count lands.
    wr(`RX2_MODE_ADDR, 8'h00);
    wr(`RXBC2_ADDR, 8'h83);
    rd(`RXBC2_ADDR, 8'h03);
    peer.rep2(2);
    rd(`IRQ_STATUS_ADDR, 8'h00);
    peer.rep2(1);
    rd(`IRQ_STATUS_ADDR, 8'h01);
    wr(`IRQ_STATUS_ADDR, 8'h0F);
    wr(`RXBC2_ADDR, 8'h00);
    peer.rep2(4);
    rd(`IRQ_STATUS_ADDR, 8'h00);
    $display("test repeat count finished");

    wr(`IRQ_MASK_ADDR, 8'h00);
    peer.send3(8'h3C, 8'h5A, 1'h0);
    chk(16'(peer.n_acc), 16'h0001);
    peer.send3(8'h11, 8'h22, 1'h1);
    rd(`IRQ_STATUS_ADDR, 8'h06);
    wr(`IRQ_STATUS_ADDR, 8'h0F);
    wr(`DLC3_ADDR, 8'h20);
    peer.send3(8'h11, 8'h22, 1'h1);
    chk(16'(peer.n_acc), 16'h0002);
    wr(`DLC3_ADDR, 8'h10);
    peer.send3(8'h3C, 8'h5A, 1'h0);
    peer.send3(8'h3C, 8'h5A, 1'h0);
    chk({8'(peer.n_acc), 8'(peer.n_dis)}, 16'h0301);
    rd(`IRQ_STATUS_ADDR, 8'h0A);
    wr(`DLC3_ADDR, 8'h00);
    peer.send3(8'h3C, 8'h5A, 1'h0);
    chk(16'(peer.n_acc), 16'h0004);
    $display("test controller three receive finished");

    // The engine sends zeros, so any one on the line is inserted.
    wr(`DLC3_ADDR, 8'h07);
    peer.bits(2, got);
    chk({mmode, idle, fcs}, 16'h0007);
    wr(`DLC3_ADDR, 8'h00);
    peer.bits(9, got);
    chk({hold, got[14:0]}, 16'h00FE);
    wr(`DLC3_ADDR, 8'h41);
    peer.bits(2, got);
    wr(`DLC3_ADDR, 8'h40);
    peer.bits(9, got);
    chk(got, 16'h0000);
    wr(`DLC3_ADDR, 8'h08);
    peer.bits(8, got);
    chk({hold, got[14:0]}, 16'h80FF);
    $display("test transmit abort finished");
    stop_test;
  end
endmodule
`default_nettype wire

// >>> dv/remote_terminal.sv
// Model of the remote terminal equipment on the far side of the data link.
`timescale 1ns/1ns
`default_nettype none
module remote_terminal (
  input  wire logic       clk,
  output logic            rx2_octet_valid,
  output logic            rx2_frame_end,
  output logic            rx2_bos_repeat,
  output logic            rx3_frame_start,
  output logic            rx3_octet_valid,
  output logic [7:0]      rx3_octet,
  output logic            rx3_frame_end,
  input  wire logic       rx3_frame_accept,
  input  wire logic       rx3_frame_discard,
  output logic            tx3_bit_tick,
  output logic            tx3_engine_bit,
  input  wire logic       tx3_line_bit
);
  int n_acc = 0;
  int n_dis = 0;

  // Lines start idle; the engine always offers zeros so an abort stands out.
  initial begin
    {rx2_octet_valid, rx2_frame_end, rx2_bos_repeat} = 3'h0;
    {rx3_frame_start, rx3_octet_valid, rx3_frame_end} = 3'h0;
    rx3_octet = 8'h00;
    tx3_bit_tick = 1'h0;
    tx3_engine_bit = 1'h0;
  end

  // Verdict pulses last one cycle, so they are counted as they pass.
  always @(posedge clk) begin
    n_acc <= n_acc + int'(rx3_frame_accept);
    n_dis <= n_dis + int'(rx3_frame_discard);
  end

  // Message of n octets then a separate end marker, each pulse followed by a gap.
  task automatic msg2(input int n);
    repeat (n) begin
      @(posedge clk) rx2_octet_valid <= 1'h1;
      @(posedge clk) rx2_octet_valid <= 1'h0;
    end
    @(posedge clk) rx2_frame_end <= 1'h1;
    @(posedge clk) rx2_frame_end <= 1'h0;
  endtask

  // Repetitions of a bit-oriented message.
  task automatic rep2(input int n);
    repeat (n) begin
      @(posedge clk) rx2_bos_repeat <= 1'h1;
      @(posedge clk) rx2_bos_repeat <= 1'h0;
    end
  endtask

  // Two-octet frame with reflected check octets; bad flips one check bit.
  task automatic send3(input logic [7:0] a, input logic [7:0] b, input logic bad);
    logic [7:0]  f [4];
    logic [15:0] c;
    c = 16'hFFFF;
    f[0] = a;
    f[1] = b;
    for (int i = 0; i < 2; i++) begin
      c ^= {8'h00, f[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
    end
    c = ~c ^ {15'h0000, bad};
    f[2] = c[7:0];
    f[3] = c[15:8];
    @(posedge clk) rx3_frame_start <= 1'h1;
    @(posedge clk) rx3_frame_start <= 1'h0;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) begin
        rx3_octet <= f[i];
        rx3_octet_valid <= 1'h1;
      end
      // Data is scrambled once released so stale octets are never reused.
      @(posedge clk) begin
        rx3_octet_valid <= 1'h0;
        rx3_octet <= ~f[i];
      end
    end
    @(posedge clk) rx3_frame_end <= 1'h1;
    @(posedge clk) rx3_frame_end <= 1'h0;
    repeat (3) @(posedge clk);
  endtask

  // Collects n line bits, oldest in the upper position.
  task automatic bits(input int n, output logic [15:0] got);
    got = 16'h0000;
    repeat (n) begin
      @(posedge clk) tx3_bit_tick <= 1'h1;
      @(posedge clk) tx3_bit_tick <= 1'h0;
      @(posedge clk) #1 got = {got[14:0], tx3_line_bit};
    end
  endtask
endmodule
`default_nettype wire

// >>> logic/abort_inserter.sv
// Transmit bit path of controller three with automatic and forced abort insertion.
`timescale 1ns/1ns
`default_nettype none
`include "hdlc_dl_params.svh"
module abort_inserter (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic bit_tick,
  input  wire logic engine_bit,
  input  wire logic message_oriented_mode,
  input  wire logic auto_abort_disable,
  input  wire logic force_abort,
  output logic      line_bit,
  output logic      engine_hold
);
  hdlc_dl_pkg::abort_state_t state_reg, state_next;
  logic       prev_mode_reg, pend_reg, pend_next, bit_reg, bit_next, hold_reg, hold_next;
  logic [2:0] cnt_reg, cnt_next;

  // A change out of message-oriented mode between ticks is remembered so the abort goes out on the next bit slot.
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    bit_next   = bit_reg;
    hold_next  = hold_reg;
    pend_next  = pend_reg | (prev_mode_reg & ~message_oriented_mode & ~auto_abort_disable);
    if (bit_tick) begin
      case (state_reg)
        hdlc_dl_pkg::ABORT_IDLE: begin
          if (force_abort) begin
            state_next = hdlc_dl_pkg::ABORT_FORCE;
            cnt_next   = 3'h1;
            bit_next   = 1'h1;
            hold_next  = 1'h1;
          end else if (pend_reg) begin
            state_next = hdlc_dl_pkg::ABORT_AUTO;
            cnt_next   = 3'h0;
            bit_next   = 1'h0;
            hold_next  = 1'h1;
            pend_next  = 1'h0;
          end else begin
            bit_next  = engine_bit;
            hold_next = 1'h0;
          end
        end
        hdlc_dl_pkg::ABORT_AUTO: begin
          if (cnt_reg == `ABORT_ONES) begin
            state_next = hdlc_dl_pkg::ABORT_IDLE;
            bit_next   = engine_bit;
            hold_next  = 1'h0;
          end else begin
            bit_next = 1'h1;
            cnt_next = cnt_reg + 3'h1;
          end
        end
        hdlc_dl_pkg::ABORT_FORCE: begin
          // Once started, at least seven ones go out even if software clears the bit early.
          if (!force_abort && cnt_reg == `ABORT_ONES) begin
            state_next = hdlc_dl_pkg::ABORT_IDLE;
            bit_next   = engine_bit;
            hold_next  = 1'h0;
          end else begin
            bit_next = 1'h1;
            cnt_next = (cnt_reg == `ABORT_ONES) ? cnt_reg : cnt_reg + 3'h1;
          end
        end
        default: state_next = hdlc_dl_pkg::ABORT_IDLE;
      endcase
    end
  end

  // Registers of the transmit bit path.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg     <= hdlc_dl_pkg::ABORT_IDLE;
      cnt_reg       <= 3'h0;
      bit_reg       <= 1'h1;
      hold_reg      <= 1'h0;
      pend_reg      <= 1'h0;
      prev_mode_reg <= 1'h0;
    end else begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      bit_reg       <= bit_next;
      hold_reg      <= hold_next;
      pend_reg      <= pend_next;
      prev_mode_reg <= message_oriented_mode;
    end
  end

  assign line_bit    = bit_reg;
  assign engine_hold = hold_reg;

  sequence s_auto_start;
    bit_tick && state_reg == hdlc_dl_pkg::ABORT_IDLE && !force_abort && pend_reg;
  endsequence
  sequence s_zero_then_ones;
    !bit_reg && state_reg == hdlc_dl_pkg::ABORT_AUTO;
  endsequence
  property p_auto_abort_zero;
    @(posedge clk) disable iff (rst) s_auto_start |=> s_zero_then_ones;
  endproperty
  a_auto_abort_zero: assert property (p_auto_abort_zero) else $error("auto abort did not start with zero");
  property p_force_ones;
    @(posedge clk) disable iff (rst) (state_reg == hdlc_dl_pkg::ABORT_FORCE) |-> bit_reg && hold_reg;
  endproperty
  a_force_ones: assert property (p_force_ones) else $error("forced abort sent a zero");
  property p_force_min;
    @(posedge clk) disable iff (rst)
      (state_reg == hdlc_dl_pkg::ABORT_FORCE && cnt_reg != `ABORT_ONES) |=> state_reg == hdlc_dl_pkg::ABORT_FORCE;
  endproperty
  a_force_min: assert property (p_force_min) else $error("forced abort shorter than seven ones");
endmodule
`default_nettype wire

// >>> logic/hdlc_datalink_control.sv
// Data-link control and status logic for receive controller two and controllers three.
`timescale 1ns/1ns
`default_nettype none
`include "hdlc_dl_params.svh"
module hdlc_datalink_control (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  output logic            irq,
  input  wire logic [1:0] framing_format,
  output logic            slc_link_active,
  output logic            sf_bits_select,
  input  wire logic       rx2_octet_valid,
  input  wire logic       rx2_frame_end,
  input  wire logic       rx2_bos_repeat,
  output logic            rx2_write_buffer,
  input  wire logic       rx3_frame_start,
  input  wire logic       rx3_octet_valid,
  input  wire logic [7:0] rx3_octet,
  input  wire logic       rx3_frame_end,
  output logic            rx3_frame_accept,
  output logic            rx3_frame_discard,
  input  wire logic       tx3_bit_tick,
  input  wire logic       tx3_engine_bit,
  output logic            tx3_line_bit,
  output logic            tx3_engine_hold,
  output logic            tx3_message_mode,
  output logic            tx3_idle_flags,
  output logic            tx3_fcs_append
);
  logic [7:0]  dlc3_reg, dlc3_next, rdata_reg, rdata_next;
  logic        rx2_mode_reg, rx2_mode_next, ptr_reg, ptr_next, wbuf_reg, wbuf_next;
  logic [6:0]  rx2_count_reg, rx2_count_next, rx2_bytes_reg, rx2_bytes_next, rx2_rep_reg, rx2_rep_next;
  logic        rx2_eot_evt;
  logic [3:0]  status_reg, status_next, mask_reg, mask_next, clear_bits;
  logic        irq_reg, irq_next, slc_reg, slc_next, sf_reg, sf_next;
  logic [7:0]  rx3_idx_reg, rx3_idx_next, rx3_len_reg, rx3_len_next;
  logic        rx3_same_reg, rx3_same_next, accept_reg, accept_next, discard_reg, discard_next;
  logic [15:0] crc_reg, crc_next;
  logic        rx3_ok_evt, rx3_err_evt, rx3_drop_evt, rx3_identical, rx3_fcs_ok, rx3_in_range;
  logic [7:0]  rx3_mem [`RX3_DEPTH];
  logic [7:0]  rx3_old;

  // Byte-wise reflected CRC-16 update, unrolled by the loop at elaboration.
  function automatic logic [15:0] fcs_update(input logic [15:0] crc, input logic [7:0] octet);
    logic [15:0] c;
    c = crc ^ {8'h00, octet};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ `FCS_POLY) : (c >> 1);
    end
    return c;
  endfunction

  // Host writes to the control registers; hardware owns the pointer bit.
  always_comb begin
    dlc3_next     = dlc3_reg;
    rx2_mode_next = rx2_mode_reg;
    mask_next     = mask_reg;
    clear_bits    = 4'h0;
    if (reg_wr) begin
      if (reg_addr == `DLC3_ADDR) begin
        dlc3_next = reg_wdata;
      end else if (reg_addr == `RX2_MODE_ADDR) begin
        rx2_mode_next = reg_wdata[0];
      end else if (reg_addr == `IRQ_STATUS_ADDR) begin
        clear_bits = reg_wdata[3:0];
      end else if (reg_addr == `IRQ_MASK_ADDR) begin
        mask_next = reg_wdata[3:0];
      end
    end
  end

  // Controller two receive status: length in message mode, repetition target in bit mode.
  always_comb begin
    rx2_count_next = rx2_count_reg;
    rx2_bytes_next = rx2_bytes_reg;
    rx2_rep_next   = rx2_rep_reg;
    ptr_next       = ptr_reg;
    rx2_eot_evt    = 1'h0;
    if (reg_wr && reg_addr == `RXBC2_ADDR) begin
      rx2_count_next = reg_wdata[6:0];
    end
    if (rx2_mode_reg) begin
      rx2_rep_next = 7'h00;
      if (rx2_frame_end) begin
        // The engine passes every octet, header and check octets alike, so the tally is the full length.
        rx2_count_next = rx2_bytes_reg;
        rx2_bytes_next = 7'h00;
        ptr_next       = wbuf_reg;
        rx2_eot_evt    = 1'h1;
      end else if (rx2_octet_valid && rx2_bytes_reg != `RX2_COUNT_MAX) begin
        rx2_bytes_next = rx2_bytes_reg + 7'h01;
      end
    end else begin
      rx2_bytes_next = 7'h00;
      if (rx2_bos_repeat && rx2_count_reg != 7'h00) begin
        if (rx2_rep_reg + 7'h01 == rx2_count_reg) begin
          rx2_eot_evt  = 1'h1;
          rx2_rep_next = 7'h00;
        end else begin
          rx2_rep_next = rx2_rep_reg + 7'h01;
        end
      end
    end
    wbuf_next = ~ptr_next;
  end

  // Controller three receive: compare against the stored frame while overwriting it.
  // Overwriting in place saves a second buffer; an identical frame leaves the contents unchanged anyway.
  assign rx3_in_range = ~rx3_idx_reg[7];
  assign rx3_old      = rx3_mem[rx3_idx_reg[6:0]];
  assign rx3_identical = rx3_same_reg && (rx3_idx_reg == rx3_len_reg);
  assign rx3_fcs_ok    = dlc3_reg[`DLC3_CHECK_DISABLE] || (crc_reg == `FCS_GOOD);
  always_comb begin
    rx3_idx_next  = rx3_idx_reg;
    rx3_same_next = rx3_same_reg;
    rx3_len_next  = rx3_len_reg;
    crc_next      = crc_reg;
    rx3_ok_evt    = 1'h0;
    rx3_err_evt   = 1'h0;
    rx3_drop_evt  = 1'h0;
    if (rx3_frame_start) begin
      rx3_idx_next  = 8'h00;
      rx3_same_next = 1'h1;
      crc_next      = `FCS_INIT;
    end else if (rx3_octet_valid) begin
      crc_next      = fcs_update(crc_reg, rx3_octet);
      rx3_same_next = rx3_same_reg && rx3_in_range && (rx3_old == rx3_octet) && (rx3_idx_reg < rx3_len_reg);
      if (rx3_in_range) begin
        rx3_idx_next = rx3_idx_reg + 8'h01;
      end
    end else if (rx3_frame_end) begin
      if (dlc3_reg[`DLC3_AUTO_DISCARD] && rx3_identical) begin
        rx3_drop_evt = 1'h1;
      end else if (rx3_fcs_ok) begin
        rx3_ok_evt   = 1'h1;
        rx3_len_next = rx3_idx_reg;
      end else begin
        rx3_err_evt  = 1'h1;
        rx3_len_next = rx3_idx_reg;
      end
    end
    accept_next  = rx3_ok_evt;
    discard_next = rx3_drop_evt;
  end

  // Receive buffer array; written in place as octets arrive.
  always_ff @(posedge clk) begin
    if (rx3_octet_valid && !rx3_frame_start && rx3_in_range) begin
      rx3_mem[rx3_idx_reg[6:0]] <= rx3_octet;
    end
  end

  // Sticky status: a new event wins over a clear in the same cycle.
  always_comb begin
    status_next = (status_reg & ~clear_bits) |
                  {rx3_drop_evt, rx3_err_evt, rx3_ok_evt, rx2_eot_evt};
    irq_next    = |(status_next & mask_next);
    slc_next    = dlc3_next[`DLC3_SLC_ENABLE] &&
                  (framing_format == `FMT_SLC || framing_format == `FMT_ESF);
    sf_next     = ~slc_next;
  end

  // Read data stand one cycle after the strobe; unmapped addresses read zero.
  always_comb begin
    rdata_next = 8'h00;
    if (reg_rd) begin
      if (reg_addr == `DLC3_ADDR) begin
        rdata_next = dlc3_reg;
      end else if (reg_addr == `RXBC2_ADDR) begin
        rdata_next = {ptr_reg, rx2_count_reg};
      end else if (reg_addr == `RX2_MODE_ADDR) begin
        rdata_next = {7'h00, rx2_mode_reg};
      end else if (reg_addr == `IRQ_STATUS_ADDR) begin
        rdata_next = {4'h0, status_reg};
      end else if (reg_addr == `IRQ_MASK_ADDR) begin
        rdata_next = {4'h0, mask_reg};
      end
    end
  end

  // All block state except the receive buffer array and the transmit bit path.
  always_ff @(posedge clk) begin
    if (rst) begin
      dlc3_reg      <= `DLC3_RESET;
      rx2_mode_reg  <= 1'h0;
      rx2_count_reg <= `RXBC2_COUNT_RESET;
      rx2_bytes_reg <= 7'h00;
      rx2_rep_reg   <= 7'h00;
      ptr_reg       <= 1'h0;
      wbuf_reg      <= 1'h1;
      status_reg    <= `IRQ_RESET;
      mask_reg      <= `IRQ_RESET;
      irq_reg       <= 1'h0;
      slc_reg       <= 1'h0;
      sf_reg        <= 1'h1;
      rdata_reg     <= 8'h00;
      rx3_idx_reg   <= 8'h00;
      rx3_len_reg   <= 8'h00;
      rx3_same_reg  <= 1'h0;
      crc_reg       <= `FCS_INIT;
      accept_reg    <= 1'h0;
      discard_reg   <= 1'h0;
    end else begin
      dlc3_reg      <= dlc3_next;
      rx2_mode_reg  <= rx2_mode_next;
      rx2_count_reg <= rx2_count_next;
      rx2_bytes_reg <= rx2_bytes_next;
      rx2_rep_reg   <= rx2_rep_next;
      ptr_reg       <= ptr_next;
      wbuf_reg      <= wbuf_next;
      status_reg    <= status_next;
      mask_reg      <= mask_next;
      irq_reg       <= irq_next;
      slc_reg       <= slc_next;
      sf_reg        <= sf_next;
      rdata_reg     <= rdata_next;
      rx3_idx_reg   <= rx3_idx_next;
      rx3_len_reg   <= rx3_len_next;
      rx3_same_reg  <= rx3_same_next;
      crc_reg       <= crc_next;
      accept_reg    <= accept_next;
      discard_reg   <= discard_next;
    end
  end

  // Transmit controller three bit path with abort insertion.
  abort_inserter u_abort (
    .clk                   (clk),
    .rst                   (rst),
    .bit_tick              (tx3_bit_tick),
    .engine_bit            (tx3_engine_bit),
    .message_oriented_mode (dlc3_reg[`DLC3_MODE_SELECT]),
    .auto_abort_disable    (dlc3_reg[`DLC3_ABORT_DISABLE]),
    .force_abort           (dlc3_reg[`DLC3_TX_ABORT]),
    .line_bit              (tx3_line_bit),
    .engine_hold           (tx3_engine_hold)
  );

  assign reg_rdata         = rdata_reg;
  assign irq               = irq_reg;
  assign slc_link_active   = slc_reg;
  assign sf_bits_select    = sf_reg;
  assign rx2_write_buffer  = wbuf_reg;
  assign rx3_frame_accept  = accept_reg;
  assign rx3_frame_discard = discard_reg;
  assign tx3_message_mode  = dlc3_reg[`DLC3_MODE_SELECT];
  assign tx3_idle_flags    = dlc3_reg[`DLC3_TX_IDLE];
  assign tx3_fcs_append    = dlc3_reg[`DLC3_FCS_APPEND];

  sequence s_mos_end;
    rx2_mode_reg && rx2_frame_end;
  endsequence
  property p_ptr_moves;
    @(posedge clk) disable iff (rst) s_mos_end |=> (ptr_reg == $past(wbuf_reg)) ##1 (wbuf_reg != ptr_reg);
  endproperty
  a_ptr_moves: assert property (p_ptr_moves) else $error("pointer did not move to written buffer");
  property p_mos_length;
    @(posedge clk) disable iff (rst) s_mos_end |=> rx2_count_reg == $past(rx2_bytes_reg);
  endproperty
  a_mos_length: assert property (p_mos_length) else $error("message length not reported");
  property p_zero_count;
    @(posedge clk) disable iff (rst) (!rx2_mode_reg && rx2_count_reg == 7'h00) |-> !rx2_eot_evt;
  endproperty
  a_zero_count: assert property (p_zero_count) else $error("end of transfer with zero count");
  property p_bos_target;
    @(posedge clk) disable iff (rst)
      (!rx2_mode_reg && rx2_bos_repeat && rx2_count_reg != 7'h00 && rx2_rep_reg + 7'h01 == rx2_count_reg)
      |=> status_reg[`IRQ_RX2_EOT];
  endproperty
  a_bos_target: assert property (p_bos_target) else $error("repetition target missed");
  property p_slc_gate;
    @(posedge clk) disable iff (rst)
      (framing_format == `FMT_SF) |=> !slc_reg && sf_reg;
  endproperty
  a_slc_gate: assert property (p_slc_gate) else $error("loop link active in plain superframe");
  property p_fcs_error;
    @(posedge clk) disable iff (rst)
      (rx3_frame_end && !rx3_frame_start && !rx3_octet_valid && !dlc3_reg[`DLC3_CHECK_DISABLE] &&
       crc_reg != `FCS_GOOD && !(dlc3_reg[`DLC3_AUTO_DISCARD] && rx3_identical))
      |=> status_reg[`IRQ_RX3_FCS_ERROR] && !accept_reg;
  endproperty
  a_fcs_error: assert property (p_fcs_error) else $error("bad check sequence accepted");
  property p_no_discard;
    @(posedge clk) disable iff (rst) !dlc3_reg[`DLC3_AUTO_DISCARD] |=> !discard_reg;
  endproperty
  a_no_discard: assert property (p_no_discard) else $error("frame dropped with discard off");
  property p_irq_level;
    @(posedge clk) disable iff (rst) |(status_reg & mask_reg) |-> irq_reg;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt low with unmasked status");
endmodule
`default_nettype wire

// >>> logic/hdlc_dl_params.svh
// Offsets, field positions, reset values and codes of the data-link control block.
`ifndef HDLC_DL_PARAMS_SVH
`define HDLC_DL_PARAMS_SVH

// Register offsets on the host port.
`define RX2_MODE_ADDR      12'h150
`define RXBC2_ADDR         12'h151
`define DLC3_ADDR          12'h153
`define IRQ_STATUS_ADDR    12'h154
`define IRQ_MASK_ADDR      12'h155

// Reset values.
`define DLC3_RESET         8'h00
`define RXBC2_COUNT_RESET  7'h00
`define IRQ_RESET          4'h0

// Control register three field positions.
`define DLC3_SLC_ENABLE    7
`define DLC3_ABORT_DISABLE 6
`define DLC3_CHECK_DISABLE 5
`define DLC3_AUTO_DISCARD  4
`define DLC3_TX_ABORT      3
`define DLC3_TX_IDLE       2
`define DLC3_FCS_APPEND    1
`define DLC3_MODE_SELECT   0

// Interrupt status bit positions.
`define IRQ_RX2_EOT        0
`define IRQ_RX3_ACCEPT     1
`define IRQ_RX3_FCS_ERROR  2
`define IRQ_RX3_DISCARD    3

// Framing format codes presented by the framer.
`define FMT_SF             2'h0
`define FMT_ESF            2'h1
`define FMT_SLC            2'h2

// Frame check sequence constants, buffer size, count limit and abort length.
`define FCS_INIT           16'hFFFF
`define FCS_POLY           16'h8408
`define FCS_GOOD           16'hF0B8
`define RX3_DEPTH          128
`define RX2_COUNT_MAX      7'h7F
`define ABORT_ONES         3'h7

`endif

// >>> logic/hdlc_dl_pkg.sv
// Types shared by the data-link control block.
package hdlc_dl_pkg;
  typedef enum logic [1:0] {
    ABORT_IDLE  = 2'b00,
    ABORT_AUTO  = 2'b01,
    ABORT_FORCE = 2'b10
  } abort_state_t;
endpackage
